// file: hw/psf_pkg.sv
package psf_pkg;
  localparam logic [7:0] PSF_PSW_ADDR = 8'hD0;
  localparam logic [7:0] PSF_PSW_RESET = 8'h00;
  localparam int PSF_CY_BIT = 7;
  localparam int PSF_AC_BIT = 6;
  localparam int PSF_F0_BIT = 5;
  localparam int PSF_RS_HI = 4;
  localparam int PSF_RS_LO = 3;
  localparam int PSF_OV_BIT = 2;
  localparam int PSF_F1_BIT = 1;
  localparam int PSF_P_BIT = 0;
  localparam logic [7:0] PSF_BYTE_MAX = 8'hFF;
  localparam logic [4:0] PSF_BANK_SPAN = 5'h08;

  typedef enum logic [2:0] {
    PSF_OP_NONE,
    PSF_OP_ADD,
    PSF_OP_ADD_WITH_CARRY,
    PSF_OP_SUBTRACT_WITH_BORROW,
    PSF_OP_MUL,
    PSF_OP_DIV
  } psf_op_t;

  // One arithmetic request from the execution unit
  typedef struct packed {
    logic valid;
    psf_op_t op;
    logic [7:0] a;
    logic [7:0] b;
  } psf_alu_req_t;

  // Special function register access, byte or single bit
  typedef struct packed {
    logic wr;
    logic bit_wr;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } psf_sfr_req_t;
endpackage : psf_pkg

// file: hw/psf_bank_map.sv
`timescale 1ns/1ns
`default_nettype none
module psf_bank_map
  import psf_pkg::*;
(
  input wire logic [1:0] bank_select,
  input wire logic [2:0] reg_idx,
  output logic [7:0] ram_addr
);
  assign ram_addr = {3'h0, bank_select, reg_idx};
endmodule : psf_bank_map
`default_nettype wire

// file: hw/psf_status.sv
`timescale 1ns/1ns
`default_nettype none
module psf_status
  import psf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire psf_pkg::psf_alu_req_t alu_req,
  input wire psf_pkg::psf_sfr_req_t sfr_req,
  input wire logic [7:0] acc_value,
  input wire logic [2:0] reg_idx,
  input wire logic ptr_sel,
  output logic [7:0] psw_rdata,
  output logic [7:0] reg_addr,
  output logic [7:0] ptr_addr,
  output logic [7:0] alu_result
);
  logic carry_flag_q;
  logic aux_carry_flag_q;
  logic user_flag_zero_q;
  logic [1:0] bank_select_q;
  logic overflow_flag_q;
  logic user_flag_one_q;
  logic parity_d;
  logic [7:0] reg_addr_d;
  logic [7:0] ptr_addr_d;
  logic psw_hit;
  logic cy_d;
  logic ac_d;
  logic ov_d;
  logic cy_upd;
  logic ov_upd;
  logic [7:0] res_d;
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic [15:0] prod;
  logic [7:0] wr_byte;

  assign psw_hit = sfr_req.wr && (sfr_req.addr == PSF_PSW_ADDR);

  // Parity is not stored: it tracks the accumulator combinationally
  assign parity_d = ^acc_value;

  // Merge a single-bit write into the current word
  always_comb begin
    wr_byte = {carry_flag_q, aux_carry_flag_q, user_flag_zero_q, bank_select_q,
               overflow_flag_q, user_flag_one_q, parity_d};
    if (sfr_req.bit_wr) begin
      wr_byte[sfr_req.bit_sel] = sfr_req.wdata[0];
    end else begin
      wr_byte = sfr_req.wdata;
    end
  end

  always_comb begin
    cy_d = 1'b0;
    ac_d = 1'b0;
    ov_d = 1'b0;
    cy_upd = 1'b0;
    ov_upd = 1'b0;
    res_d = 8'h00;
    sum9 = 9'h000;
    nib5 = 5'h00;
    prod = 16'h0000;
    if (alu_req.valid) begin
      case (alu_req.op)
        PSF_OP_ADD, PSF_OP_ADD_WITH_CARRY: begin
          sum9 = {1'b0, alu_req.a} + {1'b0, alu_req.b}
                 + {8'h00, (alu_req.op == PSF_OP_ADD_WITH_CARRY) & carry_flag_q};
          nib5 = {1'b0, alu_req.a[3:0]} + {1'b0, alu_req.b[3:0]}
                 + {4'h0, (alu_req.op == PSF_OP_ADD_WITH_CARRY) & carry_flag_q};
          res_d = sum9[7:0];
          cy_upd = 1'b1;
          cy_d = sum9[8];
          ac_d = nib5[4];
          ov_upd = 1'b1;
          ov_d = (alu_req.a[7] == alu_req.b[7]) && (res_d[7] != alu_req.a[7]);
        end
        PSF_OP_SUBTRACT_WITH_BORROW: begin
          sum9 = {1'b0, alu_req.a} - {1'b0, alu_req.b} - {8'h00, carry_flag_q};
          nib5 = {1'b0, alu_req.a[3:0]} - {1'b0, alu_req.b[3:0]} - {4'h0, carry_flag_q};
          res_d = sum9[7:0];
          cy_upd = 1'b1;
          cy_d = sum9[8];
          ac_d = nib5[4];
          ov_upd = 1'b1;
          ov_d = (alu_req.a[7] != alu_req.b[7]) && (res_d[7] != alu_req.a[7]);
        end
        PSF_OP_MUL: begin
          prod = {8'h00, alu_req.a} * {8'h00, alu_req.b};
          res_d = prod[7:0];
          // Multiply is arithmetic too, so both carries are cleared
          cy_upd = 1'b1;
          cy_d = 1'b0;
          ac_d = 1'b0;
          ov_upd = 1'b1;
          ov_d = (prod > {8'h00, PSF_BYTE_MAX});
        end
        PSF_OP_DIV: begin
          cy_upd = 1'b1;
          cy_d = 1'b0;
          ac_d = 1'b0;
          ov_upd = 1'b1;
          ov_d = (alu_req.b == 8'h00);
          res_d = ov_d ? 8'h00 : alu_req.a / alu_req.b;
        end
        default: begin
          res_d = 8'h00;
        end
      endcase
    end
  end

  // Arithmetic flags: an instruction in the same cycle as a firmware write wins
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      carry_flag_q <= PSF_PSW_RESET[PSF_CY_BIT];
      aux_carry_flag_q <= PSF_PSW_RESET[PSF_AC_BIT];
      overflow_flag_q <= PSF_PSW_RESET[PSF_OV_BIT];
    end else begin
      if (cy_upd) begin
        carry_flag_q <= cy_d;
        aux_carry_flag_q <= ac_d;
      end else if (psw_hit) begin
        carry_flag_q <= wr_byte[PSF_CY_BIT];
        aux_carry_flag_q <= wr_byte[PSF_AC_BIT];
      end
      if (ov_upd) begin
        overflow_flag_q <= ov_d;
      end else if (psw_hit) begin
        overflow_flag_q <= wr_byte[PSF_OV_BIT];
      end
    end
  end

  // Software-owned fields
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      user_flag_zero_q <= PSF_PSW_RESET[PSF_F0_BIT];
      user_flag_one_q <= PSF_PSW_RESET[PSF_F1_BIT];
      bank_select_q <= PSF_PSW_RESET[PSF_RS_HI:PSF_RS_LO];
    end else if (psw_hit) begin
      user_flag_zero_q <= wr_byte[PSF_F0_BIT];
      user_flag_one_q <= wr_byte[PSF_F1_BIT];
      bank_select_q <= wr_byte[PSF_RS_HI:PSF_RS_LO];
    end
  end

  psf_bank_map u_reg_map (
    .bank_select(bank_select_q),
    .reg_idx(reg_idx),
    .ram_addr(reg_addr_d)
  );

  psf_bank_map u_ptr_map (
    .bank_select(bank_select_q),
    .reg_idx({2'b00, ptr_sel}),
    .ram_addr(ptr_addr_d)
  );

  // Outputs are registered, so they lag the state by one cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      psw_rdata <= PSF_PSW_RESET;
      reg_addr <= 8'h00;
      ptr_addr <= 8'h00;
      alu_result <= 8'h00;
    end else begin
      psw_rdata <= {carry_flag_q, aux_carry_flag_q, user_flag_zero_q, bank_select_q,
                    overflow_flag_q, user_flag_one_q, parity_d};
      reg_addr <= reg_addr_d;
      ptr_addr <= ptr_addr_d;
      alu_result <= res_d;
    end
  end

  carry_add_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    alu_req.valid && alu_req.op == PSF_OP_ADD |=>
      carry_flag_q == (({1'b0, $past(alu_req.a)} + {1'b0, $past(alu_req.b)}) > 9'h0FF))
    else $error("carry wrong after add");
  aux_add_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    alu_req.valid && alu_req.op == PSF_OP_ADD |=>
      aux_carry_flag_q == (({1'b0, $past(alu_req.a[3:0])} + {1'b0, $past(alu_req.b[3:0])}) > 5'h0F))
    else $error("aux carry wrong after add");
  muldiv_carry_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    alu_req.valid && (alu_req.op == PSF_OP_MUL || alu_req.op == PSF_OP_DIV) |=>
      !carry_flag_q && !aux_carry_flag_q)
    else $error("carry not cleared by multiply or divide");
  user_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !psw_hit |=> $stable(user_flag_zero_q))
    else $error("user flag zero changed without write");
  bank_range_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    1'b1 |=> reg_addr == {3'h0, $past(bank_select_q), $past(reg_idx)})
    else $error("bank address wrong");
  mul_ov_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    alu_req.valid && alu_req.op == PSF_OP_MUL |=>
      overflow_flag_q == (({8'h00, $past(alu_req.a)} * {8'h00, $past(alu_req.b)}) > 16'h00FF))
    else $error("multiply overflow wrong");
  div_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    alu_req.valid && alu_req.op == PSF_OP_DIV && alu_req.b == 8'h00 |=> overflow_flag_q)
    else $error("divide by zero not flagged");
  user_one_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !psw_hit |=> $stable(user_flag_one_q))
    else $error("user flag one changed without write");
  parity_out_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    1'b1 |=> psw_rdata[PSF_P_BIT] == ^$past(acc_value))
    else $error("parity wrong");
  ptr_bank_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    1'b1 |=> ptr_addr[7:1] == {3'h0, $past(bank_select_q), 2'b00})
    else $error("pointer register outside bank");
endmodule : psf_status
`default_nettype wire

// file: test/psf_exec_model.sv
`timescale 1ns/1ns
`default_nettype none
// Stands in for the execution unit: one request word per issued instruction
module psf_exec_model
  import psf_pkg::*;
(
  input wire logic go,
  input wire psf_pkg::psf_op_t op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  output psf_pkg::psf_alu_req_t alu_req
);
  import psf_pkg::*;
  // An idle bus carries PSF_OP_NONE and the inverted operands, with the valid bit clear
  assign alu_req = go ? {1'b1, op, a, b} : {1'b0, PSF_OP_NONE, ~a, ~b};
endmodule : psf_exec_model
`default_nettype wire

// file: test/program_status_flags_tb.sv
`timescale 1ns/1ns
`default_nettype none
module program_status_flags_tb;
  import psf_pkg::*;
  typedef struct {psf_op_t op; logic [7:0] a; logic [7:0] b; logic [7:0] program_status_word; logic [7:0] res;} psf_row_t;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic go = 1'b0;
  psf_op_t op = PSF_OP_NONE;
  logic [7:0] a = 8'h00;
  logic [7:0] b = 8'h00;
  psf_alu_req_t alu_req;
  psf_sfr_req_t sfr_req = '0;
  logic [7:0] acc_value = 8'h00;
  logic [2:0] reg_idx = 3'h0;
  logic ptr_sel = 1'b0;
  logic [7:0] psw_rdata, reg_addr, ptr_addr, alu_result;
  int fails = 0;
  int samples_checked = 0;
  // Rows run in order: the carry-in of each row is the carry left by the row before
  psf_row_t rows [11] = '{
    '{PSF_OP_ADD, 8'hFF, 8'h01, 8'hC0, 8'h00},
    '{PSF_OP_ADD_WITH_CARRY, 8'h7F, 8'h00, 8'h44, 8'h80},
    '{PSF_OP_SUBTRACT_WITH_BORROW, 8'h00, 8'h01, 8'hC0, 8'hFF},
    '{PSF_OP_SUBTRACT_WITH_BORROW, 8'h80, 8'h00, 8'h44, 8'h7F},
    '{PSF_OP_ADD, 8'h01, 8'h01, 8'h00, 8'h02},
    '{PSF_OP_MUL, 8'h10, 8'h10, 8'h04, 8'h00},
    '{PSF_OP_MUL, 8'h0F, 8'h11, 8'h00, 8'hFF},
    '{PSF_OP_DIV, 8'h07, 8'h00, 8'h04, 8'h00},
    '{PSF_OP_DIV, 8'h07, 8'h02, 8'h00, 8'h03},
    '{PSF_OP_ADD, 8'h7F, 8'h01, 8'h44, 8'h80},
    '{PSF_OP_NONE, 8'h00, 8'h00, 8'h44, 8'h00}};
  always #5 ref_clk = ~ref_clk;
  psf_exec_model model (.go(go), .op(op), .a(a), .b(b), .alu_req(alu_req));
  psf_status uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .alu_req(alu_req), .sfr_req(sfr_req),
    .acc_value(acc_value), .reg_idx(reg_idx), .ptr_sel(ptr_sel), .psw_rdata(psw_rdata),
    .reg_addr(reg_addr), .ptr_addr(ptr_addr), .alu_result(alu_result));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    if (fails == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  // Request is taken on the next rising edge and shows one edge later
  task automatic run();
    @(negedge ref_clk);
    go = 1'b0;
    sfr_req = '0;
    @(negedge ref_clk);
  endtask : run
  initial begin
    repeat (3) @(negedge ref_clk);
    sys_rst = 1'b0;
    check(psw_rdata, PSF_PSW_RESET);
    foreach (rows[i]) begin
      op = rows[i].op;
      a = rows[i].a;
      b = rows[i].b;
      go = 1'b1;
      // The result stands for one cycle after the taking edge
      @(negedge ref_clk);
      check(alu_result, rows[i].res);
      go = 1'b0;
      @(negedge ref_clk);
      check(psw_rdata, rows[i].program_status_word);
    end
    sfr_req = '{1'b1, 1'b1, PSF_PSW_ADDR, 3'h5, 8'h01};
    run();
    sfr_req = '{1'b1, 1'b1, PSF_PSW_ADDR, 3'h1, 8'h01};
    run();
    check(psw_rdata, 8'h66);
    op = PSF_OP_ADD;
    a = 8'h01;
    b = 8'h01;
    go = 1'b1;
    run();
    check(psw_rdata, 8'h22);
    sfr_req = '{1'b1, 1'b0, 8'hD1, 3'h0, 8'hFF};
    run();
    check(psw_rdata, 8'h22);
    for (int k = 0; k < 4; k++) begin
      sfr_req = '{1'b1, 1'b0, PSF_PSW_ADDR, 3'h0, {3'h0, k[1:0], 3'h1}};
      reg_idx = 3'h7;
      ptr_sel = 1'b1;
      run();
      check(psw_rdata, {3'h0, k[1:0], 3'h0});
      check(reg_addr, {3'h0, k[1:0], 3'h7});
      check(ptr_addr, {3'h0, k[1:0], 3'h1});
    end
    acc_value = 8'h07;
    run();
    check(psw_rdata, 8'h19);
    acc_value = 8'h03;
    run();
    check(psw_rdata, 8'h18);
    finish_test();
  end
  // Whole sequence needs well under a hundred cycles
  initial begin
    #20000;
    fails++;
    finish_test();
  end
endmodule : program_status_flags_tb
`default_nettype wire
